// file: common/smou_pkg.sv
// Shared constants, opcodes and carrier types of the scalar memory op unit
package smou_pkg;
	localparam int ADDR_W = 48;
	localparam int DATA_W = 32;
	localparam int IMM_W = 21;
	localparam int MAX_STORE_DW = 4;
	localparam int CNT_W = 4;
	localparam int PEND_W = 6;
	localparam int DWORD_SHIFT = 2;
	localparam int SCRATCH_SHIFT = 6;
	localparam int LINE_SHIFT = 6;
	localparam logic [PEND_W-1:0] PEND_RESET = 6'h00;
	localparam logic [63:0] TSTAMP_RESET = 64'h0000_0000_0000_0000;

	localparam logic [7:0] OP_LOAD_X1 = 8'h00;
	localparam logic [7:0] OP_LOAD_X16 = 8'h04;
	localparam logic [7:0] OP_SCR_LOAD_X1 = 8'h05;
	localparam logic [7:0] OP_SCR_LOAD_X4 = 8'h07;
	localparam logic [7:0] OP_BUF_LOAD_X1 = 8'h08;
	localparam logic [7:0] OP_BUF_LOAD_X16 = 8'h0c;
	localparam logic [7:0] OP_STORE_X1 = 8'h10;
	localparam logic [7:0] OP_STORE_X4 = 8'h12;
	localparam logic [7:0] OP_SCR_STORE_X1 = 8'h15;
	localparam logic [7:0] OP_SCR_STORE_X4 = 8'h17;
	localparam logic [7:0] OP_BUF_STORE_X1 = 8'h18;
	localparam logic [7:0] OP_BUF_STORE_X4 = 8'h1a;
	localparam logic [7:0] OP_INV_ALL = 8'h20;
	localparam logic [7:0] OP_WB_ALL = 8'h21;
	localparam logic [7:0] OP_INV_VOL = 8'h22;
	localparam logic [7:0] OP_WB_VOL = 8'h23;
	localparam logic [7:0] OP_READ_TSTAMP = 8'h24;
	localparam logic [7:0] OP_READ_RTC = 8'h25;
	localparam logic [7:0] OP_PROBE = 8'h26;
	localparam logic [7:0] OP_LINE_DROP = 8'h28;
	localparam logic [7:0] OP_LINE_DROP_X2 = 8'h29;
	localparam logic [7:0] OP_ATOM_XCHG = 8'h40;
	localparam logic [7:0] OP_ATOM_CMPXCHG = 8'h41;
	localparam logic [7:0] OP_ATOM_SUM = 8'h42;
	localparam logic [7:0] OP_ATOM_DIFF = 8'h43;
	localparam logic [7:0] OP_ATOM_SMIN = 8'h44;

	typedef enum logic [2:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_INV_ALL,
		CMD_INV_VOL,
		CMD_WB_ALL,
		CMD_WB_VOL,
		CMD_PROBE,
		CMD_DROP
	} smou_cmd_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic offset_is_imm;
		logic [IMM_W-1:0] imm;
		logic [DATA_W-1:0] sreg_offset;
		logic [ADDR_W-1:0] base;
		logic [MAX_STORE_DW-1:0][DATA_W-1:0] data;
	} smou_issue_t;

	typedef struct packed {
		smou_cmd_t cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic lock;
	} smou_mem_req_t;

	typedef struct packed {
		logic [CNT_W-1:0] index;
		logic [DATA_W-1:0] data;
	} smou_result_t;
endpackage : smou_pkg

// file: tb/smou_mem_model.sv
// Behavioural scalar data cache with random stalls
`timescale 1ns/1ps
module smou_mem_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Requests
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire smou_pkg::smou_mem_req_t req_in,
	// Responses
	output logic rsp_valid_out,
	output logic [smou_pkg::DATA_W-1:0] rsp_data_out
);
	import smou_pkg::*;
	logic [31:0] mem [logic [47:0]];
	smou_mem_req_t log_q [$];
	int stall_pct = 0;
	// Idle response data flips every cycle so a stale word never looks fresh
	always @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 32'h0000_0000;
		end
		else if (req_valid_in && req_ready_out)
		begin
			log_q.push_back(req_in);
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b1;
			rsp_data_out <= mem.exists(req_in.addr) ? mem[req_in.addr] : {req_in.addr[15:0], ~req_in.addr[15:0]};
			if (req_in.cmd == CMD_WRITE)
				mem[req_in.addr] = req_in.wdata;
		end
		else
		begin
			req_ready_out <= ($urandom_range(99) >= stall_pct);
			rsp_valid_out <= 1'b0;
			rsp_data_out <= ~rsp_data_out;
		end
endmodule : smou_mem_model

// file: tb/smou_top_props.sv
// Port checker for the scalar memory op unit
`timescale 1ns/1ps
module smou_top_props (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Issue
	input wire logic issue_valid_in,
	input wire logic issue_ready_out,
	input wire smou_pkg::smou_issue_t issue_in,
	input wire logic [63:0] rtc_in,
	// Cache port
	input wire logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	input wire smou_pkg::smou_mem_req_t mem_req_out,
	input wire logic mem_rsp_valid_in,
	input wire logic [smou_pkg::DATA_W-1:0] mem_rsp_data_in,
	// Results
	input wire logic rslt_valid_out,
	input wire smou_pkg::smou_result_t rslt_out,
	input wire logic done_out,
	input wire logic [smou_pkg::PEND_W-1:0] scalar_mem_pending_count_out
);
	import smou_pkg::*;
	logic tk;
	logic [7:0] op_ff;
	logic [PEND_W-1:0] pend;
	logic [PEND_W-1:0] inc;
	logic [PEND_W-1:0] dec;
	assign tk = issue_valid_in && issue_ready_out;
	assign pend = scalar_mem_pending_count_out;
	assign inc = (issue_in.opcode == OP_LINE_DROP_X2) ? 6'h02 : 6'h01;
	assign dec = (op_ff == OP_LINE_DROP_X2) ? 6'h02 : 6'h01;
	// Opcode of the operation in flight
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
			op_ff <= 8'h00;
		else if (tk)
			op_ff <= issue_in.opcode;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	chk_pend_up: assert property (tk && !done_out |=> pend == $past(pend) + $past(inc))
		else $error("pending count did not rise on issue");
	chk_pend_down: assert property (done_out |-> pend == $past(pend) - dec)
		else $error("pending count did not fall on completion");
	chk_busy_after: assert property (tk |=> !issue_ready_out)
		else $error("issue accepted while busy");
	chk_req_hold: assert property (mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out && $stable(mem_req_out))
		else $error("cache request changed before acceptance");
	chk_lock_atomic: assert property (mem_req_valid_out && mem_req_out.lock |-> op_ff inside {[OP_ATOM_XCHG:OP_ATOM_SMIN]})
		else $error("lock raised outside an atomic");
	chk_drop_line: assert property (mem_req_valid_out && mem_req_out.cmd == CMD_DROP |-> mem_req_out.addr[5:0] == 6'h00)
		else $error("line drop address not line aligned");
	chk_done_pulse: assert property (done_out |=> !done_out)
		else $error("done held longer than one cycle");
	// First dword is registered out of the time state, one cycle after the state itself is entered
	chk_tstamp_pair: assert property (tk && issue_in.opcode == OP_READ_TSTAMP |=> ##1 rslt_valid_out && rslt_out.index == 4'h0
		##1 rslt_valid_out && rslt_out.index == 4'h1 && done_out)
		else $error("timestamp not returned as two dwords");
	cov_cmpxchg: cover property (tk && issue_in.opcode == OP_ATOM_CMPXCHG);
	cov_stall: cover property (mem_req_valid_out && !mem_req_ready_in);
	cov_drop2: cover property (tk && issue_in.opcode == OP_LINE_DROP_X2);
endmodule : smou_top_props
bind smou_top smou_top_props u_props (.clk_in, .rst_in, .issue_valid_in, .issue_ready_out, .issue_in, .rtc_in,
	.mem_req_valid_out, .mem_req_ready_in, .mem_req_out, .mem_rsp_valid_in, .mem_rsp_data_in, .rslt_valid_out,
	.rslt_out, .done_out, .scalar_mem_pending_count_out);

// file: tb/tb_scalar_memory_op_unit.sv
// Self-checking bench for the scalar memory op unit
`timescale 1ns/1ps
module tb_scalar_memory_op_unit;
	import smou_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic issue_valid_in = 1'b0;
	logic issue_ready_out;
	smou_issue_t issue_in = '0;
	logic [63:0] rtc_in = 64'h0000_0000_0000_0000;
	// Reference free-running timestamp: cleared in reset, one step per clock
	logic [63:0] tsm = 64'h0000_0000_0000_0000;
	logic mem_req_valid_out;
	logic mem_req_ready_in;
	smou_mem_req_t mem_req_out;
	logic mem_rsp_valid_in;
	logic [DATA_W-1:0] mem_rsp_data_in;
	logic rslt_valid_out;
	smou_result_t rslt_out;
	logic done_out;
	logic [PEND_W-1:0] scalar_mem_pending_count_out;
	int mismatches = 0;
	int n_compared = 0;
	logic [31:0] exp_mem [logic [47:0]];
	smou_result_t rs_q [$];
	smou_top dut (.clk_in, .rst_in, .issue_valid_in, .issue_ready_out, .issue_in, .rtc_in, .mem_req_valid_out,
		.mem_req_ready_in, .mem_req_out, .mem_rsp_valid_in, .mem_rsp_data_in, .rslt_valid_out, .rslt_out,
		.done_out, .scalar_mem_pending_count_out);
	smou_mem_model mdl (.clk_in, .rst_in, .req_valid_in(mem_req_valid_out), .req_ready_out(mem_req_ready_in),
		.req_in(mem_req_out), .rsp_valid_out(mem_rsp_valid_in), .rsp_data_out(mem_rsp_data_in));
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) #1 rtc_in = rtc_in + 64'h0000_0001_0000_0003;
	always @(posedge clk_in)
		if (rst_in)
			tsm <= 64'h0000_0000_0000_0000;
		else
			tsm <= tsm + 64'h0000_0000_0000_0001;
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	function automatic logic [31:0] rdm(input logic [47:0] a);
		return exp_mem.exists(a) ? exp_mem[a] : {a[15:0], ~a[15:0]};
	endfunction : rdm
	task automatic run_op(input logic [7:0] op, input logic imm, input logic eq);
		smou_issue_t s;
		smou_mem_req_t r;
		logic [47:0] a;
		logic [31:0] old;
		logic [31:0] nv;
		logic [63:0] rtc;
		logic [63:0] ts;
		logic [2:0] ec;
		int nb;
		int k;
		s.opcode = op;
		s.offset_is_imm = imm;
		s.imm = 21'($urandom);
		s.sreg_offset = $urandom;
		s.base = {16'($urandom), $urandom};
		s.data = {$urandom, $urandom, $urandom, $urandom};
		if (imm)
			a = s.base + {{27{s.imm[20]}}, s.imm};
		else if (op inside {[5:7], [21:23]})
			a = s.base + {10'h000, s.sreg_offset, 6'h00};
		else
			a = s.base + {16'h0000, s.sreg_offset[31:2], 2'b00};
		if (op inside {40, 41})
			a = {a[47:6], 6'h00};
		nb = 1;
		ec = CMD_READ;
		case (op) inside
			[0:4]: nb = 1 << op;
			[5:7]: nb = 1 << (op - 5);
			[8:12]: nb = 1 << (op - 8);
			[16:18]: nb = 1 << (op - 16);
			[21:23]: nb = 1 << (op - 21);
			[24:26]: nb = 1 << (op - 24);
			32: ec = CMD_INV_ALL;
			33: ec = CMD_WB_ALL;
			34: ec = CMD_INV_VOL;
			35: ec = CMD_WB_VOL;
			36, 37: nb = 0;
			38: ec = CMD_PROBE;
			40: ec = CMD_DROP;
			41: ec = CMD_DROP;
			default: nb = 2;
		endcase
		if (op == 41)
			nb = 2;
		if (op inside {[16:26]})
			ec = CMD_WRITE;
		old = rdm(a);
		if (eq)
			s.data[1] = old;
		case (op)
			64: nv = s.data[0];
			65: nv = (old == s.data[1]) ? s.data[0] : old;
			66: nv = old + s.data[0];
			67: nv = old - s.data[0];
			default: nv = ($signed(s.data[0]) < $signed(old)) ? s.data[0] : old;
		endcase
		@(posedge clk_in);
		#1;
		issue_in = s;
		issue_valid_in = 1'b1;
		mdl.log_q.delete();
		rs_q.delete();
		check("ready", issue_ready_out, 1'b1);
		@(posedge clk_in);
		rtc = rtc_in;
		ts = tsm;
		#1;
		issue_valid_in = 1'b0;
		check("pend up", scalar_mem_pending_count_out, (op == 41) ? 2 : 1);
		for (k = 0; k < 400 && done_out !== 1'b1; k++)
		begin
			@(posedge clk_in);
			#1;
			if (rslt_valid_out === 1'b1)
				rs_q.push_back(rslt_out);
		end
		if (k == 400)
		begin
			mismatches++;
			give_verdict();
		end
		check("pend end", scalar_mem_pending_count_out, 0);
		check("beats", mdl.log_q.size(), nb);
		for (k = 0; k < nb; k++)
		begin
			r = mdl.log_q[k];
			check("cmd", r.cmd, (op >= 64) ? ((k == 0) ? CMD_READ : CMD_WRITE) : ec);
			check("lock", r.lock, op >= 64);
			if (!(op inside {[32:35]}))
				check("addr", r.addr, (op >= 64) ? a : 48'(a + ((op > 39) ? 64 : 4) * k));
			if (op inside {[16:26]})
				check("wdata", r.wdata, s.data[k]);
			if (op inside {[16:26]})
				exp_mem[48'(a + 4 * k)] = s.data[k];
			if (op <= 12)
				check("load", rs_q[k], {4'(k), rdm(48'(a + 4 * k))});
			if (op >= 64 && k == 1)
				check("new", r.wdata, nv);
		end
		if (op >= 64)
			check("old", rs_q[0], {4'h0, old});
		if (op >= 64)
			exp_mem[a] = nv;
		if (op == 37)
			check("rtc", {rs_q[1].data, rs_q[0].data}, rtc);
		if (op == 36)
			check("tstamp", {rs_q[1].data, rs_q[0].data}, ts);
		check("results", rs_q.size(), (op <= 12) ? nb : (op inside {36, 37}) ? 2 : (op >= 64));
	endtask : run_op
	initial
	begin
		void'($urandom(46691));
		repeat (12) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		for (int p = 0; p < 2; p++)
		begin
			mdl.stall_pct = p * 60;
			for (int o = 0; o < 69; o++)
				if (o inside {[0:12], [16:18], [21:26], [32:38], [40:41], [64:68]})
				begin
					run_op(8'(o), 1'b0, 1'b0);
					run_op(8'(o), 1'b1, 1'b1);
				end
			$display("test pass %0d done", p);
		end
		give_verdict();
	end
endmodule : tb_scalar_memory_op_unit

// file: verilog/smou_top.sv
// Scalar memory instruction decoder and sequencer
`timescale 1ns/1ps
// Operation
// - Plain loads 0..4 read 1, 2, 4, 8 or 16 dwords into scalar registers
// - Register offset of plain access is unsigned bytes, low two bits ignored
// - Immediate offset is a signed 21-bit byte offset for every access
// - Scratch loads 5..7 read 1, 2, 4 dwords; register offset counts 64-byte units
// - Buffer loads 8..12 read 1..16 dwords with plain-load offset forming
// - Plain stores 16..18 write 1, 2, 4 dwords to the cache
// - Scratch stores 21..23 write 1, 2, 4 dwords with 64-byte-unit register offset
// - Buffer stores 24..26 write 1, 2, 4 dwords with plain-store offset forming
// - Opcode 32 invalidates the whole cache, 34 only volatile lines
// - Opcode 33 writes back all dirty data, 35 only dirty volatile lines
// - Opcode 36 returns the 64-bit timestamp, 37 the 64-bit real-time clock
// - Opcode 38 probes or prefetches the address, returning no data
// - Opcode 40 drops one dirty 64-byte line, address low six bits cleared
// - Opcode 41 drops two consecutive lines; pending count rises 2, else 1
// - Exchange 64 stores data and returns the previous word
// - Compare-exchange 65 stores word 0 if memory equals word 1, returns old
// - Sum 66 and difference 67 update memory and return the old word
// - Signed minimum stores the smaller value signed, returns the old word
module smou_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Instruction issue
	input wire logic issue_valid_in,
	output logic issue_ready_out,
	input wire smou_pkg::smou_issue_t issue_in,
	// Real-time counter from the same clock
	input wire logic [63:0] rtc_in,
	// Scalar data cache port
	output logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	output smou_pkg::smou_mem_req_t mem_req_out,
	input wire logic mem_rsp_valid_in,
	input wire logic [smou_pkg::DATA_W-1:0] mem_rsp_data_in,
	// Scalar register write-back
	output logic rslt_valid_out,
	output smou_pkg::smou_result_t rslt_out,
	// Completion and pending count
	output logic done_out,
	output logic [smou_pkg::PEND_W-1:0] scalar_mem_pending_count_out
);
	import smou_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_RSP, ST_AWR, ST_AACK, ST_TIME} smou_state_t;

	smou_state_t state_ff, nxt_state;
	smou_issue_t op_ff, nxt_op;
	smou_mem_req_t req_ff, nxt_req;
	smou_result_t rslt_ff, nxt_rslt;
	logic rslt_valid_ff, nxt_rslt_valid;
	logic done_ff, nxt_done;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [CNT_W:0] total_ff, nxt_total;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] old_ff, nxt_old;
	logic [63:0] time_ff, nxt_time;
	logic [63:0] tstamp_ff, nxt_tstamp;
	logic [PEND_W-1:0] pend_ff, nxt_pend;
	logic [PEND_W-1:0] pend_inc, pend_dec;

	function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
		in_range = (op >= lo) && (op <= hi);
	endfunction : in_range

	function automatic logic is_load(input logic [7:0] op);
		is_load = in_range(op, OP_LOAD_X1, OP_LOAD_X16) || in_range(op, OP_SCR_LOAD_X1, OP_SCR_LOAD_X4)
			|| in_range(op, OP_BUF_LOAD_X1, OP_BUF_LOAD_X16);
	endfunction : is_load

	function automatic logic is_store(input logic [7:0] op);
		is_store = in_range(op, OP_STORE_X1, OP_STORE_X4) || in_range(op, OP_SCR_STORE_X1, OP_SCR_STORE_X4)
			|| in_range(op, OP_BUF_STORE_X1, OP_BUF_STORE_X4);
	endfunction : is_store

	function automatic logic is_atomic(input logic [7:0] op);
		is_atomic = in_range(op, OP_ATOM_XCHG, OP_ATOM_SMIN);
	endfunction : is_atomic

	function automatic logic is_scratch(input logic [7:0] op);
		is_scratch = in_range(op, OP_SCR_LOAD_X1, OP_SCR_LOAD_X4) || in_range(op, OP_SCR_STORE_X1, OP_SCR_STORE_X4);
	endfunction : is_scratch

	// Dword or line count of an opcode, one for everything that is not sized
	function automatic logic [CNT_W:0] op_count(input logic [7:0] op);
		logic [7:0] first;
		first = op;
		if (in_range(op, OP_LOAD_X1, OP_LOAD_X16))
			first = OP_LOAD_X1;
		else if (in_range(op, OP_SCR_LOAD_X1, OP_SCR_LOAD_X4))
			first = OP_SCR_LOAD_X1;
		else if (in_range(op, OP_BUF_LOAD_X1, OP_BUF_LOAD_X16))
			first = OP_BUF_LOAD_X1;
		else if (in_range(op, OP_STORE_X1, OP_STORE_X4))
			first = OP_STORE_X1;
		else if (in_range(op, OP_SCR_STORE_X1, OP_SCR_STORE_X4))
			first = OP_SCR_STORE_X1;
		else if (in_range(op, OP_BUF_STORE_X1, OP_BUF_STORE_X4))
			first = OP_BUF_STORE_X1;
		if (op == OP_LINE_DROP_X2)
			op_count = 5'h02;
		else
			op_count = 5'h01 << (op - first);
	endfunction : op_count

	// Byte offset from the register or the immediate
	function automatic logic [ADDR_W-1:0] form_offset(input smou_issue_t iss);
		if (iss.offset_is_imm)
			form_offset = {{(ADDR_W-IMM_W){iss.imm[IMM_W-1]}}, iss.imm};
		else if (is_scratch(iss.opcode))
			form_offset = {{(ADDR_W-DATA_W-SCRATCH_SHIFT){1'b0}}, iss.sreg_offset, {SCRATCH_SHIFT{1'b0}}};
		else
			form_offset = {{(ADDR_W-DATA_W){1'b0}}, iss.sreg_offset[DATA_W-1:DWORD_SHIFT], {DWORD_SHIFT{1'b0}}};
	endfunction : form_offset

	function automatic logic [DATA_W-1:0] atom_calc(input logic [7:0] op, input logic [DATA_W-1:0] mem,
		input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
		unique case (op)
			OP_ATOM_XCHG: atom_calc = d0;
			OP_ATOM_CMPXCHG: atom_calc = (mem == d1) ? d0 : mem;
			OP_ATOM_SUM: atom_calc = mem + d0;
			OP_ATOM_DIFF: atom_calc = mem - d0;
			OP_ATOM_SMIN: atom_calc = ($signed(d0) < $signed(mem)) ? d0 : mem;
			default: atom_calc = mem;
		endcase
	endfunction : atom_calc

	function automatic smou_cmd_t op_cmd(input logic [7:0] op);
		unique case (op)
			OP_INV_ALL: op_cmd = CMD_INV_ALL;
			OP_INV_VOL: op_cmd = CMD_INV_VOL;
			OP_WB_ALL: op_cmd = CMD_WB_ALL;
			OP_WB_VOL: op_cmd = CMD_WB_VOL;
			OP_PROBE: op_cmd = CMD_PROBE;
			OP_LINE_DROP, OP_LINE_DROP_X2: op_cmd = CMD_DROP;
			default: op_cmd = is_store(op) ? CMD_WRITE : CMD_READ;
		endcase
	endfunction : op_cmd

	// Address of beat cnt: dword steps for data, line steps for drops
	function automatic logic [ADDR_W-1:0] beat_addr(input logic [7:0] op, input logic [ADDR_W-1:0] a,
		input logic [CNT_W-1:0] c);
		if (op == OP_LINE_DROP || op == OP_LINE_DROP_X2)
			beat_addr = {a[ADDR_W-1:LINE_SHIFT], {LINE_SHIFT{1'b0}}}
				+ {{(ADDR_W-CNT_W-LINE_SHIFT){1'b0}}, c, {LINE_SHIFT{1'b0}}};
		else
			beat_addr = a + {{(ADDR_W-CNT_W-DWORD_SHIFT){1'b0}}, c, {DWORD_SHIFT{1'b0}}};
	endfunction : beat_addr

	function automatic smou_mem_req_t build_req(input smou_issue_t iss, input logic [ADDR_W-1:0] a,
		input logic [CNT_W-1:0] c);
		build_req.cmd = op_cmd(iss.opcode);
		build_req.addr = beat_addr(iss.opcode, a, c);
		build_req.wdata = iss.data[c[1:0]];
		// Lock opens on the atomic read and is held through its write
		build_req.lock = is_atomic(iss.opcode);
	endfunction : build_req

	assign issue_ready_out = (state_ff == ST_IDLE);
	assign mem_req_valid_out = (state_ff == ST_REQ) || (state_ff == ST_AWR);
	assign mem_req_out = req_ff;
	assign rslt_valid_out = rslt_valid_ff;
	assign rslt_out = rslt_ff;
	assign done_out = done_ff;
	assign scalar_mem_pending_count_out = pend_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_req = req_ff;
		nxt_rslt = rslt_ff;
		nxt_rslt_valid = 1'b0;
		nxt_done = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_total = total_ff;
		nxt_addr = addr_ff;
		nxt_old = old_ff;
		nxt_time = time_ff;
		nxt_tstamp = tstamp_ff + 64'h0000_0000_0000_0001;
		pend_inc = '0;
		pend_dec = '0;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (issue_valid_in)
				begin
					nxt_op = issue_in;
					nxt_cnt = '0;
					nxt_total = op_count(issue_in.opcode);
					nxt_addr = issue_in.base + form_offset(issue_in);
					pend_inc = (issue_in.opcode == OP_LINE_DROP_X2) ? 6'h02 : 6'h01;
					if (issue_in.opcode == OP_READ_TSTAMP || issue_in.opcode == OP_READ_RTC)
					begin
						nxt_time = (issue_in.opcode == OP_READ_TSTAMP) ? tstamp_ff : rtc_in;
						nxt_state = ST_TIME;
					end
					else
					begin
						nxt_req = build_req(issue_in, issue_in.base + form_offset(issue_in), '0);
						nxt_state = ST_REQ;
					end
				end
			end
			ST_REQ:
			begin
				if (mem_req_ready_in)
					nxt_state = ST_RSP;
			end
			ST_RSP:
			begin
				if (mem_rsp_valid_in)
				begin
					if (is_atomic(op_ff.opcode))
					begin
						// Old word kept for return; write goes out with lock still held
						nxt_old = mem_rsp_data_in;
						nxt_req.cmd = CMD_WRITE;
						nxt_req.wdata = atom_calc(op_ff.opcode, mem_rsp_data_in, op_ff.data[0], op_ff.data[1]);
						nxt_state = ST_AWR;
					end
					else
					begin
						if (is_load(op_ff.opcode))
						begin
							nxt_rslt_valid = 1'b1;
							nxt_rslt.index = cnt_ff;
							nxt_rslt.data = mem_rsp_data_in;
						end
						if ({1'b0, cnt_ff} + 5'h01 == total_ff)
						begin
							nxt_done = 1'b1;
							pend_dec = (op_ff.opcode == OP_LINE_DROP_X2) ? 6'h02 : 6'h01;
							nxt_state = ST_IDLE;
						end
						else
						begin
							nxt_cnt = cnt_ff + 4'h1;
							nxt_req = build_req(op_ff, addr_ff, cnt_ff + 4'h1);
							nxt_state = ST_REQ;
						end
					end
				end
			end
			ST_AWR:
			begin
				if (mem_req_ready_in)
					nxt_state = ST_AACK;
			end
			ST_AACK:
			begin
				if (mem_rsp_valid_in)
				begin
					nxt_req.lock = 1'b0;
					nxt_rslt_valid = 1'b1;
					nxt_rslt.index = '0;
					nxt_rslt.data = old_ff;
					nxt_done = 1'b1;
					pend_dec = 6'h01;
					nxt_state = ST_IDLE;
				end
			end
			ST_TIME:
			begin
				// Low dword first, then high dword into the next register
				nxt_rslt_valid = 1'b1;
				nxt_rslt.index = cnt_ff;
				nxt_rslt.data = cnt_ff[0] ? time_ff[63:32] : time_ff[31:0];
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff[0])
				begin
					nxt_done = 1'b1;
					pend_dec = 6'h01;
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		// Issue and completion in one cycle both count
		nxt_pend = pend_ff + pend_inc - pend_dec;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_ff <= ST_IDLE;
			op_ff <= '0;
			req_ff <= '0;
			rslt_ff <= '0;
			rslt_valid_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= '0;
			total_ff <= '0;
			addr_ff <= '0;
			old_ff <= '0;
			time_ff <= TSTAMP_RESET;
			tstamp_ff <= TSTAMP_RESET;
			pend_ff <= PEND_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			req_ff <= nxt_req;
			rslt_ff <= nxt_rslt;
			rslt_valid_ff <= nxt_rslt_valid;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			total_ff <= nxt_total;
			addr_ff <= nxt_addr;
			old_ff <= nxt_old;
			time_ff <= nxt_time;
			tstamp_ff <= nxt_tstamp;
			pend_ff <= nxt_pend;
		end
	end
endmodule : smou_top
